// File: design/conv_backend.sv
// Contract
// - flag every sample whose differential input exceeds the reference span.
// - flag travels through the same pipeline as its sample.
// - when enabled, stored offset is subtracted from every result.
// - test selections other than 000 and 100 replace the analog input with test voltages.
// - data pins driven only while active-low output enable is low.
// - offset disable bit: 0 enables compensation, 1 disables it.
// - offset register holds signed value from -128 to 127.
// - test codes 000 and 100 normal; others select fixed connections.
`timescale 1ns/10ps
`default_nettype none
module conv_backend
  import conv_backend_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              resetn,
  // raw core result, signed, with its out-of-span indication
  input  wire logic [DATA_W-1:0] core_data,
  input  wire logic              core_over,
  input  wire logic              core_valid,
  // parallel host port
  input  wire logic              oe_n,
  input  wire logic              cs_n,
  input  wire logic              wr_n,
  input  wire logic              rd_n,
  input  wire logic [1:0]        addr,
  input  wire logic [DATA_W-1:0] bus_in,
  output logic      [DATA_W-1:0] bus_out,
  output logic                   bus_oe,
  output logic                   range_exceeded_flag,
  // controls toward the converter core
  output logic      [2:0]        test_input_select,
  output logic      [GAIN_W-1:0] gain_sel,
  output logic                   power_down,
  output logic                   ext_ref_sel
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [DATA_W-1:0] bin1_reg;
  logic [DATA_W-1:0] bin2_reg;
  logic [1:0] a1_reg;
  logic [1:0] a2_reg;
  logic       oe_s, cs_s, wr_s, rd_s, wr_prev_reg;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sync1_reg   <= 5'h1f;
      sync2_reg   <= 5'h1f;
      wr_prev_reg <= 1'b1;
    end else begin
      sync1_reg   <= {oe_n, cs_n, wr_n, rd_n, 1'b1};
      sync2_reg   <= sync1_reg;
      wr_prev_reg <= wr_s | cs_s;
    end
    bin1_reg <= bus_in;
    bin2_reg <= bin1_reg;
    a1_reg   <= addr;
    a2_reg   <= a1_reg;
  end
  assign {oe_s, cs_s, wr_s, rd_s} = sync2_reg[4:1];
  logic wr_strobe;
  assign wr_strobe = wr_prev_reg && !wr_s && !cs_s;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic signed [OFFSET_W-1:0] offset_correction_value_reg, offset_next;
  logic [CTL_W-1:0]  ctl_reg, ctl_next;
  logic [GAIN_W-1:0] gain_reg, gain_next;
  always_comb begin
    offset_next = offset_correction_value_reg;
    ctl_next    = ctl_reg;
    gain_next   = gain_reg;
    if (wr_strobe) begin
      unique case (a2_reg)
        ADDR_OFFSET:  offset_next = bin2_reg[OFFSET_W-1:0];
        ADDR_CONTROL: ctl_next    = bin2_reg[DATA_W-1:CTL_POS];
        ADDR_GAIN:    gain_next   = bin2_reg[GAIN_W-1:0];
        ADDR_RESULT:  ;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      offset_correction_value_reg <= OFFSET_RST;
      ctl_reg  <= CTL_RST;
      gain_reg <= GAIN_RST;
    end else begin
      offset_correction_value_reg <= offset_next;
      ctl_reg  <= ctl_next;
      gain_reg <= gain_next;
    end
  end
  logic offset_comp_disable_bit;
  logic two_comp;
  logic [2:0] tsel;
  assign offset_comp_disable_bit = ctl_reg[OFFDIS_BIT-CTL_POS];
  assign two_comp = ctl_reg[FOR_BIT-CTL_POS];
  assign tsel     = ctl_reg[TSEL_MSB-CTL_POS:TSEL_LSB-CTL_POS];

  // ---------------------------------------------------------------
  // correction and pipeline
  // ---------------------------------------------------------------
  logic signed [DATA_W:0]  diff;
  logic [DATA_W-1:0]       corr;
  logic                    over_c;
  always_comb begin
    diff = {core_data[DATA_W-1], core_data};
    if (!offset_comp_disable_bit) begin
      diff = diff - (DATA_W+1)'(offset_correction_value_reg);
    end
    over_c = core_over;
    if (diff > $signed({1'b0, CODE_MAX})) begin
      corr = CODE_MAX;
    end else if (diff < $signed({1'b1, CODE_MIN})) begin
      corr = CODE_MIN;
    end else begin
      corr = diff[DATA_W-1:0];
    end
    if (!two_comp) begin
      corr[DATA_W-1] = ~corr[DATA_W-1];
    end
  end
  logic [DATA_W:0] pipe_reg [PIPE_STAGES];
  logic [PIPE_STAGES-1:0] pv_reg;
  logic fifo_ready;
  genvar g;
  generate
    for (g = 0; g < PIPE_STAGES; g++) begin : g_pipe
      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          pv_reg[g]   <= 1'b0;
          pipe_reg[g] <= '0;
        end else if (fifo_ready) begin
          pv_reg[g]   <= (g == 0) ? core_valid : pv_reg[g-1 < 0 ? 0 : g-1];
          pipe_reg[g] <= (g == 0) ? {over_c, corr} : pipe_reg[g-1 < 0 ? 0 : g-1];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // result buffer and host port
  // ---------------------------------------------------------------
  logic [DATA_W:0] f_data;
  logic            f_valid;
  logic            rd_prev_reg;
  logic            pop;
  assign pop = rd_prev_reg && !rd_s && !cs_s && (a2_reg == ADDR_RESULT);
  sample_fifo #(.WIDTH(DATA_W+1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .in_data   (pipe_reg[PIPE_STAGES-1]),
    .in_valid  (pv_reg[PIPE_STAGES-1]),
    .in_ready  (fifo_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (pop)
  );
  logic [DATA_W-1:0] bus_next;
  always_comb begin
    unique case (a2_reg)
      ADDR_RESULT:  bus_next = f_data[DATA_W-1:0];
      ADDR_GAIN:    bus_next = {{(DATA_W-GAIN_W){1'b0}}, gain_reg};
      ADDR_OFFSET:  bus_next = {{(DATA_W-OFFSET_W){1'b0}}, offset_correction_value_reg};
      ADDR_CONTROL: bus_next = {ctl_reg, {CTL_POS{1'b0}}};
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_prev_reg         <= 1'b1;
      bus_out             <= '0;
      bus_oe              <= 1'b0;
      range_exceeded_flag <= 1'b0;
      test_input_select   <= TSEL_NORMAL_A;
      gain_sel            <= GAIN_RST;
      power_down          <= 1'b0;
      ext_ref_sel         <= 1'b0;
    end else begin
      rd_prev_reg         <= rd_s | cs_s;
      bus_out             <= bus_next;
      bus_oe              <= !oe_s;
      range_exceeded_flag <= f_valid & f_data[DATA_W];
      test_input_select   <= tsel;
      gain_sel            <= gain_reg;
      power_down          <= ctl_reg[PWD_BIT-CTL_POS];
      ext_ref_sel         <= ctl_reg[REF_BIT-CTL_POS];
    end
  end
endmodule : conv_backend
`default_nettype wire

// File: design/conv_backend_pkg.sv
package conv_backend_pkg;
  // ---------------------------------------------------------------
  // data path
  // ---------------------------------------------------------------
  localparam int          DATA_W          = 14;
  localparam int          FIFO_DEPTH      = 16;
  localparam int          PIPE_STAGES     = 3;
  // ---------------------------------------------------------------
  // register addresses (register index on the address pins)
  // ---------------------------------------------------------------
  localparam logic [1:0]  ADDR_RESULT     = 2'h0;
  localparam logic [1:0]  ADDR_GAIN       = 2'h1;
  localparam logic [1:0]  ADDR_OFFSET     = 2'h2;
  localparam logic [1:0]  ADDR_CONTROL    = 2'h3;
  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int          OFFSET_W        = 8;
  localparam int          GAIN_W          = 3;
  localparam int          CTL_W           = 8;
  localparam int          CTL_POS         = 6;
  localparam int          PWD_BIT         = 13;
  localparam int          REF_BIT         = 12;
  localparam int          FOR_BIT         = 11;
  localparam int          TSEL_MSB        = 10;
  localparam int          TSEL_LSB        = 8;
  localparam int          OFFDIS_BIT      = 7;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [OFFSET_W-1:0] OFFSET_RST = 8'h00;
  localparam logic [GAIN_W-1:0]   GAIN_RST   = 3'h0;
  localparam logic [CTL_W-1:0]    CTL_RST    = 8'h00;
  // ---------------------------------------------------------------
  // test input selections and result clamp codes
  // ---------------------------------------------------------------
  localparam logic [2:0]  TSEL_NORMAL_A   = 3'h0;
  localparam logic [2:0]  TSEL_NORMAL_B   = 3'h4;
  localparam logic [DATA_W-1:0] CODE_MIN  = 14'h2000;
  localparam logic [DATA_W-1:0] CODE_MAX  = 14'h1fff;
endpackage : conv_backend_pkg

// File: design/sample_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    wr_next;
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    rd_next;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;

  always_comb begin
    push     = in_valid && (cnt_reg != (AW+1)'(DEPTH));
    pop      = out_ready && (cnt_reg != '0);
    wr_next  = push ? wr_reg + 1'b1 : wr_reg;
    rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
endmodule : sample_fifo
`default_nettype wire

// File: verification/conv_backend_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module conv_backend_monitor
  import conv_backend_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              resetn,
  input wire logic              oe_n,
  input wire logic              cs_n,
  input wire logic              wr_n,
  input wire logic [1:0]        addr,
  input wire logic [DATA_W-1:0] bus_in,
  input wire logic [DATA_W-1:0] bus_out,
  input wire logic              bus_oe,
  input wire logic [2:0]        test_input_select,
  input wire logic [GAIN_W-1:0] gain_sel,
  input wire logic              power_down,
  input wire logic              ext_ref_sel
);
  // ----
  // checks
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // pins pass two flops, so five cycles cover the whole latency
  sequence wr_to(logic [1:0] a);
    $fell(wr_n) && !cs_n && addr == a;
  endsequence
  chk_oe_on: assert property (!oe_n [*5] |-> bus_oe)
    else $error("data pins idle with oe_n low");
  chk_oe_off: assert property (oe_n [*5] |-> !bus_oe)
    else $error("data pins driven with oe_n high");
  chk_oe_rise: assert property ($rose(bus_oe) |-> $past(oe_n, 2) == 1'b0)
    else $error("drive began without oe_n low");
  chk_tsel_wr: assert property (wr_to(ADDR_CONTROL) |->
    ##5 test_input_select == bus_in[TSEL_MSB:TSEL_LSB]) else $error("test select wrong");
  chk_mode_wr: assert property (wr_to(ADDR_CONTROL) |->
    ##5 power_down == bus_in[PWD_BIT] && ext_ref_sel == bus_in[REF_BIT])
    else $error("mode bits wrong");
  chk_gain_wr: assert property (wr_to(ADDR_GAIN) |-> ##5 gain_sel == bus_in[GAIN_W-1:0])
    else $error("gain select wrong");
  chk_ctl_hold: assert property (wr_n [*5] |->
    $stable(test_input_select) && $stable(gain_sel)) else $error("control changed unwritten");
  chk_off_zext: assert property ((addr == ADDR_OFFSET) [*5] |->
    bus_out[DATA_W-1:OFFSET_W] == '0) else $error("offset upper bits set");
endmodule : conv_backend_monitor
bind conv_backend conv_backend_monitor i_mon (.core_clk(core_clk), .resetn(resetn),
  .oe_n(oe_n), .cs_n(cs_n), .wr_n(wr_n), .addr(addr), .bus_in(bus_in),
  .bus_out(bus_out), .bus_oe(bus_oe), .test_input_select(test_input_select),
  .gain_sel(gain_sel), .power_down(power_down), .ext_ref_sel(ext_ref_sel));
`default_nettype wire

// File: verification/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model
  import conv_backend_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic [DATA_W-1:0] bus_out,
  input  wire logic              bus_oe,
  output logic                   oe_n,
  output logic                   cs_n,
  output logic                   wr_n,
  output logic                   rd_n,
  output logic      [1:0]        addr,
  output logic      [DATA_W-1:0] bus_in,
  output logic                   seen,
  output logic      [DATA_W-1:0] seen_val
);
  // ----
  // bus cycles
  // ----
  initial begin
    {oe_n, cs_n, wr_n, rd_n, seen} = 5'h1e;
    addr = 2'h0;
    bus_in = '0;
    seen_val = '0;
  end
  task automatic wr(input logic [1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    addr <= a;
    bus_in <= d;
    cs_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    wr_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    wr_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    cs_n <= 1'b1;
    bus_in <= ~d; // released data must not look valid
    repeat (3) @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [1:0] a);
    @(posedge core_clk);
    addr <= a;
    cs_n <= 1'b0;
    oe_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    seen <= 1'b1;
    seen_val <= bus_oe ? bus_out : ~bus_out;
    @(posedge core_clk);
    seen <= 1'b0;
    rd_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    cs_n <= 1'b1;
    oe_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : rd
endmodule : host_model
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import conv_backend_pkg::*;
  logic              core_clk = 0, resetn = 0, core_over = 0, core_valid = 0;
  logic [DATA_W-1:0] core_data = '0, bus_in, bus_out, seen_val, v, g, fd[16];
  logic [1:0]        addr;
  logic [2:0]        test_input_select, gain_sel;
  logic [7:0]        off;
  logic              oe_n, cs_n, wr_n, rd_n, bus_oe, range_exceeded_flag, seen;
  logic              power_down, ext_ref_sel, dis, fo[16];
  logic [DATA_W-1:0] exp_q[$];
  int                bad_count = 0, compares = 0, seed = 76, r, d;
  always #5 core_clk = ~core_clk;
  conv_backend i_conv_backend (.core_clk(core_clk), .resetn(resetn), .core_data(core_data),
    .core_over(core_over), .core_valid(core_valid), .oe_n(oe_n), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .addr(addr), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .range_exceeded_flag(range_exceeded_flag), .test_input_select(test_input_select),
    .gain_sel(gain_sel), .power_down(power_down), .ext_ref_sel(ext_ref_sel));
  host_model i_host (.core_clk(core_clk), .bus_out(bus_out), .bus_oe(bus_oe), .oe_n(oe_n),
    .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr), .bus_in(bus_in), .seen(seen),
    .seen_val(seen_val));
  // ----
  // checking
  // ----
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test;
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  always @(posedge core_clk) if (seen === 1'b1) begin
    if (exp_q.size() > 0)
      check(seen_val, exp_q.pop_front());
    else
      check(seen_val, ~seen_val);
  end
  task automatic push(input logic [DATA_W-1:0] s, input logic o);
    @(posedge core_clk);
    core_data <= s;
    core_over <= o;
    core_valid <= 1'b1;
    @(posedge core_clk);
    core_valid <= 1'b0;
    core_data <= ~s;
  endtask : push
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    stop_test();
  end
  // ----
  // scenarios
  // ----
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    check(bus_oe, 1'b0);
    exp_q.push_back('0);
    i_host.rd(ADDR_OFFSET);
    for (int t = 0; t < 8; t++) begin
      v = {t[0], t[1], 1'b1, t[2:0], 8'h00};
      i_host.wr(ADDR_CONTROL, v);
      check(test_input_select, v[10:8]);
      check({power_down, ext_ref_sel}, v[13:12]);
    end
    g = 14'($random(seed));
    i_host.wr(ADDR_GAIN, g);
    check(gain_sel, g[2:0]);
    i_host.wr(ADDR_CONTROL, 14'h0800);
    r = $random(seed) % 128; // zero-input result fits the offset span
    push(14'(r), 1'b0);
    exp_q.push_back(14'(r));
    i_host.rd(ADDR_RESULT);
    i_host.wr(ADDR_OFFSET, {6'h00, 8'(r)});
    exp_q.push_back({6'h00, 8'(r)});
    i_host.rd(ADDR_OFFSET);
    for (int k = 0; k < 4; k++) begin
      off = (k == 1) ? 8'h80 : (k == 2) ? 8'h7f : 8'(r);
      dis = (k == 3);
      if (k > 0 && !dis) i_host.wr(ADDR_OFFSET, {6'h00, off});
      if (dis) i_host.wr(ADDR_CONTROL, 14'h0880);
      d = $random(seed) % 4096;
      v = dis ? 14'(d) : 14'(d - signed'(off));
      g[0] = $random(seed);
      push(14'(d), g[0]);
      repeat (6) @(posedge core_clk);
      check(range_exceeded_flag, g[0]);
      exp_q.push_back(v);
      i_host.rd(ADDR_RESULT);
    end
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      fd[i] = 14'($random(seed));
      fo[i] = $random(seed);
      push(fd[i], fo[i]);
    end
    repeat (6) @(posedge core_clk);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      check(range_exceeded_flag, fo[i]);
      exp_q.push_back(fd[i]);
      i_host.rd(ADDR_RESULT);
    end
    i_host.wr(ADDR_CONTROL, 14'h0080);
    push(14'h0005, 1'b0);
    exp_q.push_back(14'h2005);
    i_host.rd(ADDR_RESULT);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
